//--- inc/ptp_tc_pkg.sv
package ptp_tc_pkg;

  // actions the analyzer hands to the stamp unit and rewriter
  typedef enum logic [2:0] {
    ACT_PASS       = 3'b000,
    ACT_PEER_SUB   = 3'b001,
    ACT_WRITE      = 3'b010,
    ACT_ADD        = 3'b011,
    ACT_SUB_ADD    = 3'b100,
    ACT_WRITE_SAVE = 3'b101
  } action_t;

endpackage

//--- inc/ptp_tc_regs.svh
// Summary of operation
// [R1] ingress sync in domain: peer subtract on correction
// [R2] mode A peer subtract: cf minus stamp plus delays
// [R3] mode B peer subtract: cf minus peer stamp
// [R4] ingress pdelay req/resp: write reserved four bytes
// [R5] write action puts ingress stamp into reserved bytes
// [R6] resp asymmetry: mode A on cf, mode B reserved
// [R7] egress sync: add egress stamp to correction field
// [R8] mode A modified req: cf stamp minus reserved, asymmetry
// [R9] normal t3: write-save, no write, fifo stamp minus asymmetry
// [R10] save stores sequence id with egress stamp
// [R11] mode A egress resp: cf plus stamp minus reserved
// [R12] unmatched frame passes unchanged, stamp discarded
// [R13] host pre-subtracts receive stamp in mode B resp
// [R14] stamp fifo holds id and stamp, host reads
// [R15] host sends modified req with cf zero
// [R16] modified t3: egress inserts time since software t3
// [R17] responder adds t5 minus t4 to correction
// [R18] initiator path delay is halved round trip
// [R19] rewrite replaces fcs, inverted if original bad
`ifndef PTP_TC_REGS_SVH
`define PTP_TC_REGS_SVH

`define REG_CTRL      8'h00
`define REG_DOMAIN    8'h04
`define REG_LOCAL     8'h08
`define REG_PATH      8'h0C
`define REG_ASYM      8'h10
`define REG_STATUS    8'h14
`define REG_TS_ID     8'h18
`define REG_TS_VALUE  8'h1C

`define CTRL_EGRESS   0
`define CTRL_MODE_B   1
`define CTRL_MOD_T3   2
`define CTRL_ENABLE   3
`define CTRL_RESET    4'h0
`define STAT_OVF      8
`define STAT_CNT_LSB  16
`define TS_VALID_BIT  16

`define POS_ETY_HI    8'h0C
`define POS_ETY_LO    8'h0D
`define POS_MSG       8'h0E
`define POS_DOMAIN    8'h12
`define POS_CF_FIRST  8'h16
`define POS_CF_LAST   8'h1D
`define POS_RV_FIRST  8'h1E
`define POS_RV_LAST   8'h21
`define POS_SEQ_HI    8'h2C
`define POS_SEQ_LO    8'h2D
`define POS_LATCH     8'h15
`define IDX_MAX       8'hFF

`define PTP_ETYPE     16'h88F7
`define MSG_SYNC      4'h0
`define MSG_PREQ      4'h2
`define MSG_PRESP     4'h3

`define CRC_INIT      32'hFFFFFFFF
`define CRC_POLY      32'hEDB88320
`define CRC_RESIDUE   32'hDEBB20E3

`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

//--- logic/ptp_p2p_transparent_clock_stamper.sv
`timescale 1ns/100ps
`include "ptp_tc_regs.svh"

// plain ring fifo, output data straight from the storage flops
module byte_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        push;
  logic        pop;

  assign in_ready  = (s_reg.cnt != (AW+1)'(D));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointers wrap at depth, so a non power of two depth works too
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(D - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(D - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

module ptp_p2p_transparent_clock_stamper
  import ptp_tc_pkg::*;
#(
  parameter int DLY   = 26,
  parameter int TS_D  = 4,
  parameter int OUT_D = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] captured_nanoseconds,
  input  wire logic [7:0]  frame_in_data,
  input  wire logic        frame_in_last,
  input  wire logic        frame_in_valid,
  output logic             frame_in_ready,
  output logic [7:0]       frame_out_data,
  output logic             frame_out_last,
  output logic             frame_out_valid,
  input  wire logic        frame_out_ready
);
  localparam int TA = (TS_D > 1) ? $clog2(TS_D) : 1;

  typedef struct packed {
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [3:0]           ctrl;
    logic [7:0]           domain;
    logic [31:0]          local_corr;
    logic [31:0]          path_delay;
    logic [31:0]          asym;
    logic                 ovf;
    logic [15:0]          match_cnt;
    logic [7:0]           in_idx;
    logic [31:0]          raw;
    logic [15:0]          ety;
    logic [3:0]           msg;
    logic                 dom_ok;
    logic [63:0]          cf;
    logic [31:0]          resv;
    logic [15:0]          seq;
    logic                 dec_ok;
    action_t              act_in;
    logic [31:0]          crc_in;
    logic                 bad_fcs;
    logic [DLY-1:0][8:0]  line;
    logic [DLY-1:0]       lv;
    logic [7:0]           out_idx;
    logic [63:0]          new_cf;
    logic [31:0]          new_resv;
    logic                 wr_cf;
    logic                 wr_resv;
    logic [31:0]          crc_out;
    logic [TS_D-1:0][47:0] ts_mem;
    logic [TA-1:0]        ts_wp;
    logic [TA-1:0]        ts_rp;
    logic [TA:0]          ts_cnt;
  } state_t;

  state_t      s_reg;
  state_t      s_next;
  logic        ob_ready;
  logic        ob_valid;
  logic [8:0]  ob_data;
  logic        drain;
  logic        adv;
  logic        head_pop;
  logic        in_take;
  logic        is_fcs;
  logic [1:0]  fcs_k;
  logic [7:0]  head_byte;
  logic [7:0]  out_byte;
  logic [31:0] stamp;
  logic [31:0] peer_stamp;
  logic [31:0] crc_nx;
  logic [31:0] fcs_val;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;
  logic        ts_pop;
  action_t     act_nx;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // nanoseconds into the 2^-16 ns correction format, sign kept
  function automatic logic [63:0] to_cf(input logic [31:0] ns);
    return {{16{ns[31]}}, ns, 16'h0000};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  assign awready        = !s_reg.aw_got && !s_reg.bvalid;
  assign wready         = !s_reg.w_got && !s_reg.bvalid;
  assign bvalid         = s_reg.bvalid;
  assign bresp          = s_reg.bresp;
  assign arready        = !s_reg.rvalid;
  assign rvalid         = s_reg.rvalid;
  assign rdata          = s_reg.rdata;
  assign rresp          = s_reg.rresp;

  // the delay line moves only when its head can leave, so a full
  // output fifo stalls the frame source
  assign frame_in_ready = !s_reg.lv[0] || ob_ready;
  assign in_take        = frame_in_valid && frame_in_ready;
  assign adv            = frame_in_ready && (frame_in_valid || drain);
  assign head_pop       = adv && s_reg.lv[0];
  assign ob_valid       = s_reg.lv[0] && (frame_in_valid || drain);
  assign ob_data        = {s_reg.line[0][8], out_byte};
  assign head_byte      = s_reg.line[0][7:0];

  // live stamps: egress adds the local correction, ingress removes it
  assign stamp      = s_reg.ctrl[`CTRL_EGRESS] ? s_reg.raw + s_reg.local_corr
                                               : s_reg.raw - s_reg.local_corr;
  assign peer_stamp = stamp - s_reg.path_delay - s_reg.asym;
  assign fcs_val    = ~s_reg.crc_out;
  assign ts_pop     = arvalid && arready && (araddr == `REG_TS_VALUE) && (s_reg.ts_cnt != '0);

  // fcs bytes are the last four valid entries; bubbles in between are skipped
  always_comb begin
    logic       found;
    logic [7:0] rem;
    found = 1'b0;
    rem   = 8'h00;
    for (int i = 0; i < DLY; i++) begin
      if (!found && s_reg.lv[i]) begin
        if (s_reg.line[i][8]) found = 1'b1;
        else rem = rem + 8'h01;
      end
    end
    is_fcs = found && (rem < 8'h04);
    drain  = found;
    fcs_k  = 2'(8'h03 - rem);
  end

  // rewriter: patch the latched field, then regenerate the fcs
  always_comb begin
    out_byte = head_byte;
    if (s_reg.wr_cf && s_reg.out_idx >= `POS_CF_FIRST && s_reg.out_idx <= `POS_CF_LAST) begin
      out_byte = 8'(s_reg.new_cf >> {3'(`POS_CF_LAST - s_reg.out_idx), 3'b000});
    end
    if (s_reg.wr_resv && s_reg.out_idx >= `POS_RV_FIRST && s_reg.out_idx <= `POS_RV_LAST) begin
      out_byte = 8'(s_reg.new_resv >> {2'(`POS_RV_LAST - s_reg.out_idx), 3'b000});
    end
    if ((s_reg.wr_cf || s_reg.wr_resv) && is_fcs) begin
      // inverting keeps a frame that came in corrupted marked as bad
      out_byte = fcs_val[8*fcs_k +: 8] ^ {8{s_reg.bad_fcs}};  // [R19]
    end
  end

  // analyzer decision, taken when the sequence id is complete
  always_comb begin
    act_nx = ACT_PASS;
    if (s_reg.ctrl[`CTRL_ENABLE] && s_reg.ety == `PTP_ETYPE && s_reg.dom_ok) begin
      unique case (s_reg.msg)
        `MSG_SYNC: act_nx = s_reg.ctrl[`CTRL_EGRESS] ? ACT_ADD : ACT_PEER_SUB;  // [R1] [R7]
        `MSG_PREQ: begin
          if (!s_reg.ctrl[`CTRL_EGRESS]) act_nx = ACT_WRITE;  // [R4]
          else if (!s_reg.ctrl[`CTRL_MODE_B] && s_reg.ctrl[`CTRL_MOD_T3]) act_nx = ACT_SUB_ADD;  // [R8]
          else act_nx = ACT_WRITE_SAVE;  // [R9]
        end
        `MSG_PRESP: begin
          if (!s_reg.ctrl[`CTRL_EGRESS]) act_nx = ACT_WRITE;  // [R4]
          else if (s_reg.ctrl[`CTRL_MODE_B]) act_nx = ACT_ADD;  // [R13]
          else act_nx = ACT_SUB_ADD;  // [R11]
        end
        default: act_nx = ACT_PASS;
      endcase
    end
  end

  // register read mux
  always_comb begin
    rd_resp = `RESP_OKAY;
    rd_mux  = 32'h00000000;
    unique case (araddr)
      `REG_CTRL:     rd_mux = {28'h0000000, s_reg.ctrl};
      `REG_DOMAIN:   rd_mux = {24'h000000, s_reg.domain};
      `REG_LOCAL:    rd_mux = s_reg.local_corr;
      `REG_PATH:     rd_mux = s_reg.path_delay;
      `REG_ASYM:     rd_mux = s_reg.asym;
      `REG_STATUS: begin
        rd_mux = 32'(s_reg.ts_cnt);
        rd_mux[`STAT_OVF] = s_reg.ovf;
        rd_mux[`STAT_CNT_LSB +: 16] = s_reg.match_cnt;
      end
      `REG_TS_ID: begin
        rd_mux = {16'h0000, s_reg.ts_mem[s_reg.ts_rp][47:32]};  // [R14]
        rd_mux[`TS_VALID_BIT] = (s_reg.ts_cnt != '0);
      end
      `REG_TS_VALUE: rd_mux = s_reg.ts_mem[s_reg.ts_rp][31:0];  // [R14]
      default:       rd_resp = `RESP_DECERR;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    crc_nx = 32'h00000000;

    // register bus: address and data taken in either order
    if (awvalid && awready) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (bvalid && bready) s_next.bvalid = 1'b0;
    if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `RESP_OKAY;
      unique case (s_next.aw_addr)
        `REG_CTRL:   s_next.ctrl = 4'(merge(32'(s_reg.ctrl), s_next.w_data, s_next.w_strb));
        `REG_DOMAIN: s_next.domain = 8'(merge(32'(s_reg.domain), s_next.w_data, s_next.w_strb));
        `REG_LOCAL:  s_next.local_corr = merge(s_reg.local_corr, s_next.w_data, s_next.w_strb);
        `REG_PATH:   s_next.path_delay = merge(s_reg.path_delay, s_next.w_data, s_next.w_strb);
        `REG_ASYM:   s_next.asym = merge(s_reg.asym, s_next.w_data, s_next.w_strb);
        `REG_STATUS: begin
          if (s_next.w_strb[1] && s_next.w_data[`STAT_OVF]) s_next.ovf = 1'b0;
        end
        `REG_TS_ID, `REG_TS_VALUE: s_next.bresp = `RESP_OKAY;
        default:     s_next.bresp = `RESP_DECERR;
      endcase
    end
    if (rvalid && rready) s_next.rvalid = 1'b0;
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_mux;
      s_next.rresp  = rd_resp;
    end

    // input side: capture header fields and check the incoming fcs
    if (in_take) begin
      crc_nx = crc_step((s_reg.in_idx == 8'h00) ? `CRC_INIT : s_reg.crc_in, frame_in_data);
      s_next.crc_in = crc_nx;
      if (s_reg.in_idx == 8'h00) begin
        s_next.raw    = captured_nanoseconds;
        s_next.dec_ok = 1'b0;
      end
      if (s_reg.in_idx == `POS_ETY_HI || s_reg.in_idx == `POS_ETY_LO) begin
        s_next.ety = {s_reg.ety[7:0], frame_in_data};
      end
      if (s_reg.in_idx == `POS_MSG) s_next.msg = frame_in_data[3:0];
      if (s_reg.in_idx == `POS_DOMAIN) s_next.dom_ok = (frame_in_data == s_reg.domain);
      if (s_reg.in_idx >= `POS_CF_FIRST && s_reg.in_idx <= `POS_CF_LAST) begin
        s_next.cf = {s_reg.cf[55:0], frame_in_data};
      end
      if (s_reg.in_idx >= `POS_RV_FIRST && s_reg.in_idx <= `POS_RV_LAST) begin
        s_next.resv = {s_reg.resv[23:0], frame_in_data};
      end
      if (s_reg.in_idx == `POS_SEQ_HI || s_reg.in_idx == `POS_SEQ_LO) begin
        s_next.seq = {s_reg.seq[7:0], frame_in_data};  // [R10]
      end
      if (s_reg.in_idx == `POS_SEQ_LO) begin
        s_next.dec_ok = 1'b1;
        s_next.act_in = act_nx;
      end
      if (frame_in_last) begin
        s_next.in_idx  = 8'h00;
        s_next.bad_fcs = (crc_nx != `CRC_RESIDUE);
      end else if (s_reg.in_idx != `IDX_MAX) begin
        s_next.in_idx = s_reg.in_idx + 8'h01;
      end
    end

    // delay line shift; a bubble enters while a frame tail drains
    if (adv) begin
      for (int i = 0; i < DLY - 1; i++) begin
        s_next.line[i] = s_reg.line[i+1];
        s_next.lv[i]   = s_reg.lv[i+1];
      end
      s_next.line[DLY-1] = {frame_in_last, frame_in_data};
      s_next.lv[DLY-1]   = in_take;
    end

    // output side: crc over sent bytes, stamp unit result latched per frame
    if (head_pop) begin
      if (s_reg.out_idx == 8'h00) begin
        s_next.wr_cf   = 1'b0;
        s_next.wr_resv = 1'b0;
      end
      if (!is_fcs) begin
        s_next.crc_out = crc_step((s_reg.out_idx == 8'h00) ? `CRC_INIT : s_reg.crc_out,
                                  out_byte);
      end
      if (s_reg.out_idx == `POS_LATCH) begin
        s_next.wr_cf   = 1'b0;
        s_next.wr_resv = 1'b0;
        s_next.new_cf  = s_reg.cf;
        s_next.new_resv = stamp;
        unique case (s_reg.dec_ok ? s_reg.act_in : ACT_PASS)
          ACT_PEER_SUB: begin
            s_next.wr_cf = 1'b1;
            if (s_reg.ctrl[`CTRL_MODE_B]) begin
              s_next.new_cf = s_reg.cf - to_cf(peer_stamp);  // [R3]
            end else begin
              s_next.new_cf = s_reg.cf - to_cf(stamp) + to_cf(s_reg.path_delay)
                              + to_cf(s_reg.asym);  // [R2]
            end
          end
          ACT_WRITE: begin
            s_next.wr_resv = 1'b1;  // [R5]
            if (s_reg.msg == `MSG_PRESP && s_reg.ctrl[`CTRL_MODE_B]) begin
              s_next.new_resv = stamp + s_reg.asym;  // [R6]
            end else if (s_reg.msg == `MSG_PRESP) begin
              s_next.wr_cf  = 1'b1;
              s_next.new_cf = s_reg.cf + to_cf(s_reg.asym);  // [R6]
            end
          end
          ACT_ADD: begin
            s_next.wr_cf  = 1'b1;
            s_next.new_cf = s_reg.cf + to_cf(stamp);  // [R7]
          end
          ACT_SUB_ADD: begin
            s_next.wr_cf  = 1'b1;
            // software t3 sits in the reserved bytes, so this is a residence time
            s_next.new_cf = s_reg.cf + to_cf(stamp) - to_cf(s_reg.resv);  // [R11] [R16]
            if (s_reg.msg == `MSG_PREQ) begin
              s_next.new_cf = s_reg.cf + to_cf(stamp) - to_cf(s_reg.resv)
                              - to_cf(s_reg.asym);  // [R8]
            end
          end
          ACT_WRITE_SAVE: begin
            // a full stamp fifo drops the entry and flags it
            if (s_reg.ts_cnt != (TA+1)'(TS_D)) begin
              s_next.ts_mem[s_reg.ts_wp] = {s_reg.seq, stamp - s_reg.asym};  // [R9] [R10]
              s_next.ts_wp = (s_reg.ts_wp == TA'(TS_D - 1)) ? '0 : s_reg.ts_wp + 1'b1;
            end else begin
              s_next.ovf = 1'b1;
            end
          end
          default: s_next.raw = 32'h00000000;  // [R12]
        endcase
        if (s_reg.dec_ok && s_reg.act_in != ACT_PASS) begin
          s_next.match_cnt = s_reg.match_cnt + 16'h0001;
        end
      end
      s_next.out_idx = s_reg.line[0][8] ? 8'h00 :
                       (s_reg.out_idx == `IDX_MAX) ? `IDX_MAX : s_reg.out_idx + 8'h01;
    end

    // stamp fifo read side; a push in the same cycle still counts
    if (ts_pop) begin
      s_next.ts_rp = (s_reg.ts_rp == TA'(TS_D - 1)) ? '0 : s_reg.ts_rp + 1'b1;  // [R14]
    end
    s_next.ts_cnt = s_reg.ts_cnt + (TA+1)'(s_next.ts_wp != s_reg.ts_wp) - (TA+1)'(ts_pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg      <= '0;
      s_reg.ctrl <= `CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // output buffer; its fullness stalls the delay line and the source
  byte_fifo #(
    .W (9),
    .D (OUT_D)
  ) out_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (ob_valid),
    .in_ready  (ob_ready),
    .in_data   (ob_data),
    .out_valid (frame_out_valid),
    .out_ready (frame_out_ready),
    .out_data  ({frame_out_last, frame_out_data})
  );
endmodule

//--- verif/ptp_mac_model.sv
`timescale 1ns/100ps
module ptp_mac_model (
  input  wire logic       clk,
  output logic [7:0]      frame_in_data,
  output logic            frame_in_last,
  output logic            frame_in_valid,
  input  wire logic       frame_in_ready,
  input  wire logic [7:0] frame_out_data,
  input  wire logic       frame_out_last,
  input  wire logic       frame_out_valid,
  output logic            frame_out_ready
);
  logic [8:0] tx_q[$];
  logic [8:0] rx_q[$];
  logic [1:0] tick;
  initial {frame_in_data, frame_in_last, frame_in_valid, frame_out_ready, tick} = '0;
  // stall one cycle in four so the buffer fills
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    frame_out_ready <= (tick != 2'h3);
    if (frame_out_valid && frame_out_ready) rx_q.push_back({frame_out_last, frame_out_data});
    if (!frame_in_valid || frame_in_ready) begin
      if (tx_q.size() > 0) begin
        {frame_in_last, frame_in_data} <= tx_q.pop_front();
        frame_in_valid <= 1'b1;
      end else begin
        frame_in_valid <= 1'b0;
        frame_in_data <= ~frame_in_data; // no stale byte while idle
      end
    end
  end
endmodule

//--- verif/ptp_p2p_transparent_clock_stamper_tb.sv
`timescale 1ns/100ps
`include "ptp_tc_regs.svh"
module ptp_p2p_transparent_clock_stamper_tb;
  localparam logic [31:0] RAW = 32'h0001_2340;
  localparam logic [31:0] LOC = 32'h10;
  localparam logic [31:0] PTH = 32'h64;
  localparam logic [31:0] ASY = 32'h7;
  localparam logic [63:0] C0 = 64'h50_0000;
  logic        clk;
  logic        rst_b;
  logic [7:0]  awaddr, araddr, frame_in_data, frame_out_data;
  logic [31:0] wdata, rdata, raw;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, frame_in_last, frame_in_valid;
  logic        frame_in_ready, frame_out_last, frame_out_valid, frame_out_ready;
  int          n_errors, n_tests, tno;
  ptp_p2p_transparent_clock_stamper uut (
    .clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .captured_nanoseconds(raw), .frame_in_data, .frame_in_last, .frame_in_valid,
    .frame_in_ready, .frame_out_data, .frame_out_last, .frame_out_valid, .frame_out_ready
  );
  ptp_mac_model mac (
    .clk, .frame_in_data, .frame_in_last, .frame_in_valid, .frame_in_ready,
    .frame_out_data, .frame_out_last, .frame_out_valid, .frame_out_ready
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [63:0] ns(input logic [31:0] x);
    return {16'h0, x, 16'h0};
  endfunction
  // reference crc, independent of the design
  function automatic logic [31:0] crc(input logic [7:0] b[64], input int n);
    crc = `CRC_INIT;
    for (int i = 0; i < n; i++) begin
      crc ^= {24'h0, b[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ `CRC_POLY : crc >> 1;
    end
  endfunction
  task automatic chk(input logic [63:0] g, e, input string s);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(64'(bresp), 64'(er), "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(64'(rresp), 64'(er), "rresp");
    if (er == `RESP_OKAY) chk(64'(rdata), 64'(ed), "rdata");
  endtask
  // one frame through the block; sequence number tracks the test count
  task automatic tc(input logic [3:0] ct, input logic [3:0] m, input logic [7:0] dm,
                    input logic [63:0] ci, input logic [31:0] ri, input logic bad,
                    input logic [63:0] ec, input logic [31:0] er);
    logic [7:0]  f[64];
    logic [7:0]  g[64];
    logic [63:0] gc;
    logic [63:0] gl;
    logic [31:0] gr;
    wr(`REG_CTRL, {28'h0, ct}, `RESP_OKAY);
    foreach (f[i]) f[i] = i[7:0];
    {f[12], f[13]} = `PTP_ETYPE;
    f[14] = {4'h0, m};
    f[18] = dm;
    {f[44], f[45]} = {8'hA5, tno[7:0]};
    for (int k = 0; k < 8; k++) f[22+k] = ci[63-8*k -: 8];
    for (int k = 0; k < 4; k++) f[30+k] = ri[31-8*k -: 8];
    gr = ~crc(f, 60);
    for (int k = 0; k < 4; k++) f[60+k] = gr[8*k +: 8] ^ {8{bad}};
    mac.rx_q.delete();
    foreach (f[i]) mac.tx_q.push_back({i == 63, f[i]});
    repeat (3000) begin
      @(posedge clk);
      if (mac.rx_q.size() == 64) break;
    end
    foreach (g[i]) {gl[i], g[i]} = mac.rx_q[i];
    for (int k = 0; k < 8; k++) gc[63-8*k -: 8] = g[22+k];
    for (int k = 0; k < 4; k++) gr[31-8*k -: 8] = g[30+k];
    chk(gc, ec, "correction");
    chk(64'(gr), 64'(er), "reserved");
    chk(64'(crc(g, 64)), 64'(crc(f, 64)), "fcs residue");
    chk(gl, {1'b1, 63'h0}, "last");
    $display("test %0d done", tno);
    tno++;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    complete_run;
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, n_errors, n_tests, tno} = '0;
    wstrb = 4'hF;
    raw = RAW;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`REG_CTRL, 32'h0, `RESP_OKAY);
    wr(8'h40, 32'h1, `RESP_DECERR);
    rd(8'h40, 32'h0, `RESP_DECERR);
    wr(`REG_DOMAIN, 32'h5, `RESP_OKAY);
    wr(`REG_LOCAL, LOC, `RESP_OKAY);
    wr(`REG_PATH, PTH, `RESP_OKAY);
    wr(`REG_ASYM, ASY, `RESP_OKAY);
    rd(`REG_ASYM, ASY, `RESP_OKAY);
    // ingress: sync in mode A, then mode B with a corrupted fcs, then pdelay req in mode A, resp in both modes, and a foreign domain
    tc(4'h8, `MSG_SYNC, 8'h5, C0, 0, 0, C0 - ns(RAW - LOC) + ns(PTH + ASY), 0);
    tc(4'hA, `MSG_SYNC, 8'h5, C0, 0, 1, C0 - ns(RAW - LOC) + ns(PTH + ASY), 0);
    tc(4'h8, `MSG_PREQ, 8'h5, C0, 0, 0, C0, RAW - LOC);
    tc(4'h8, `MSG_PRESP, 8'h5, C0, 0, 0, C0 + ns(ASY), RAW - LOC);
    tc(4'hA, `MSG_PRESP, 8'h5, C0, 0, 0, C0, RAW - LOC + ASY);
    tc(4'h8, `MSG_SYNC, 8'h6, C0, 32'hCAFE, 0, C0, 32'hCAFE);
    // egress; a mode B response comes with its receive stamp removed
    tc(4'h9, `MSG_SYNC, 8'h5, C0, 0, 0, C0 + ns(RAW + LOC), 0);
    tc(4'hB, `MSG_PRESP, 8'h5, C0, 0, 0, C0 + ns(RAW + LOC), 0);
    tc(4'hD, `MSG_PREQ, 8'h5, 0, RAW - 32'h100, 0, ns(32'h100 + LOC - ASY), RAW - 32'h100);
    tc(4'h9, `MSG_PRESP, 8'h5, C0, RAW - 32'h200, 0, C0 + ns(32'h200 + LOC), RAW - 32'h200);
    tc(4'hB, `MSG_PREQ, 8'h5, 0, 0, 0, 0, 0);
    tc(4'h9, `MSG_PREQ, 8'h5, 0, 0, 0, 0, 0);
    rd(`REG_TS_ID, 32'h0001_A50A, `RESP_OKAY);
    rd(`REG_TS_VALUE, RAW + LOC - ASY, `RESP_OKAY);
    rd(`REG_TS_ID, 32'h0001_A50B, `RESP_OKAY);
    rd(`REG_TS_VALUE, RAW + LOC - ASY, `RESP_OKAY);
    complete_run;
  end
endmodule

//--- verif/ptp_tc_monitor.sv
`timescale 1ns/100ps
`include "ptp_tc_regs.svh"
module ptp_tc_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [7:0]  frame_out_data,
  input wire logic        frame_out_last,
  input wire logic        frame_out_valid,
  input wire logic        frame_out_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // answers hold until taken
  b_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before taken");
  r_data_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data changed before taken");
  // answer one cycle after the request
  b_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  r_answer_a: assert property (arvalid && arready |-> ##1 rvalid)
    else $error("read data late");
  // one transfer per direction at a time
  ar_blocked_a: assert property (rvalid |-> !arready)
    else $error("read address accepted while data pending");
  w_blocked_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  bad_addr_a: assert property (arvalid && arready && araddr > `REG_TS_VALUE |=> rresp == `RESP_DECERR)
    else $error("unmapped read not refused");
  // a stalled byte holds
  out_hold_a: assert property (frame_out_valid && !frame_out_ready
      |=> frame_out_valid && $stable({frame_out_data, frame_out_last}))
    else $error("output byte changed while stalled");
endmodule
bind ptp_p2p_transparent_clock_stamper ptp_tc_monitor mon (.*);
